// ===== rtl/anstat_cfg.svh
// Constants for the auto-negotiation next-page and expansion status bank.
// Assumes a 5-bit management register address and 16-bit register data.
`ifndef ANSTAT_CFG_SVH
`define ANSTAT_CFG_SVH

// Register addresses.
`define ADDR_NP_ABIL    5'h05
`define ADDR_EXP_STAT   5'h06
`define ADDR_IRQ_STAT   5'h10
`define ADDR_IRQ_MASK   5'h11

// Expansion status bit positions.
`define EXP_PDF_BIT     4
`define EXP_LP_NP_BIT   3
`define EXP_LOC_NP_BIT  2
`define EXP_PAGE_BIT    1
`define EXP_LP_AN_BIT   0
`define EXP_RSVD_HI     15
`define EXP_RSVD_LO     5

// Received next-page word bit positions.
`define NP_REQ_BIT      15
`define NP_MP_BIT       13
`define NP_COMPLY_BIT   12

// Interrupt status bit positions.
`define IRQ_PAGE_BIT    0
`define IRQ_FAULT_BIT   1

// Reset values.
`define NP_WORD_RST     16'h0000
`define IRQ_RST         2'h0
`define DATA_ZERO       16'h0000
`define LOC_NP_VALUE    1'h1
`define IRQ_PAD         14'h0000
`define RSVD_ZERO       11'h000

`endif

// ===== rtl/anstat_pkg.sv
// Types shared by the auto-negotiation status bank.
// Assumes the including design pulls in anstat_cfg.svh for constants.
package anstat_pkg;

    // Received next-page word as it sits in the register.
    typedef struct packed {
        logic        next_page_request;
        logic        partner_receipt_confirm;
        logic        message_page_flag;
        logic        partner_comply_flag;
        logic        toggle;
        logic [10:0] code;
    } np_word_t;

    // One management request cycle.
    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mgmt_req_t;

    // Two interrupt sources: page received and parallel-detect fault.
    typedef logic [1:0] irq_bits_t;

endpackage

// ===== rtl/autoneg_status.sv
// Auto-negotiation received next-page word and expansion status registers.
// Assumes the auto-negotiation machine runs on clk and drives its inputs
// synchronously; the management port is a plain single-cycle strobe port.
//
// How it works
// - The negotiation machine alone sets and clears the receipt confirm bit from bursts.
// - Bit 13 shows the message page flag, marking the code field as a message code.
// - With the flag low the code field is an unformatted page, resets to zero, read-only.
// - Bit 12 shows whether the partner can comply, resets to zero, read-only.
// - Bit 11 reads the inverse of the toggle bit in the last transmitted code word.
// - The expansion status register answers at address 0x06.
// - Expansion bits 15:5 ignore writes and always read zero.
// - Expansion bit 4 shows a parallel detection fault and resets to zero.
// - Expansion bit 3 shows the partner is next-page capable and resets to zero.
// - Expansion bit 2 always reads one, the local side being next-page capable.
// - Expansion bit 1 sets on a received code word and clears on a read.
// - Expansion bit 0 shows the partner is auto-negotiation capable, reset zero.
// - The received next-page word answers at address 0x05.
// - Bit 15 shows the partner wants another next page and resets to zero.
`include "anstat_cfg.svh"

module autoneg_status
    import anstat_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      sys_rst,
    input  wire mgmt_req_t mgmt_req,
    output logic [15:0]    rd_data,
    output logic           irq,
    input  wire logic      page_rx_stb,
    input  wire np_word_t  page_rx_word,
    input  wire logic      tx_toggle_last,
    input  wire logic      pd_fault,
    input  wire logic      partner_np_capable,
    input  wire logic      partner_an_capable
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // True when a request addresses the given register.
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] target);
        hit = (addr == target);
    endfunction

    // Assembles the expansion word; reserved bits stay zero.
    function automatic logic [15:0] exp_word(
        input logic parallel_detect_fault,
        input logic lp_np,
        input logic page,
        input logic lp_an
    );
        logic [15:0] w;
        w = `DATA_ZERO;
        w[`EXP_PDF_BIT]    = parallel_detect_fault;
        w[`EXP_LP_NP_BIT]  = lp_np;
        w[`EXP_LOC_NP_BIT] = `LOC_NP_VALUE;
        w[`EXP_PAGE_BIT]   = page;
        w[`EXP_LP_AN_BIT]  = lp_an;
        exp_word = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State.

    np_word_t    np_word_r;
    logic        page_rx_r;
    logic        pdf_r;
    logic        lp_np_r;
    logic        lp_an_r;
    logic        pdf_prev_r;
    irq_bits_t   irq_stat_r;
    irq_bits_t   irq_stat_nxt;
    irq_bits_t   irq_mask_r;
    logic [15:0] rd_data_r;
    logic [15:0] rd_data_nxt;
    logic        irq_r;

    logic        exp_read;
    logic        irq_read;
    logic        fault_rise;

    assign exp_read   = mgmt_req.rd && hit(mgmt_req.addr, `ADDR_EXP_STAT);
    assign irq_read   = mgmt_req.rd && hit(mgmt_req.addr, `ADDR_IRQ_STAT);
    assign fault_rise = pd_fault && !pdf_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // Received next-page word.

    // The whole word is captured on the receive strobe, never by software,
    // so a read always sees one page rather than a mix of two.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            np_word_r <= `NP_WORD_RST;
        end else if (page_rx_stb) begin
            np_word_r.next_page_request       <= page_rx_word.next_page_request;
            np_word_r.partner_receipt_confirm <= page_rx_word.partner_receipt_confirm;
            np_word_r.message_page_flag       <= page_rx_word.message_page_flag;
            np_word_r.partner_comply_flag     <= page_rx_word.partner_comply_flag;
            np_word_r.toggle                  <= ~tx_toggle_last;
            np_word_r.code                    <= page_rx_word.code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Expansion status.

    // Page flag: set on a received word, cleared by a read. The set wins
    // so a page arriving in the clearing cycle is still reported.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            page_rx_r <= 1'h0;
        end else if (page_rx_stb) begin
            page_rx_r <= 1'h1;
        end else if (exp_read) begin
            page_rx_r <= 1'h0;
        end
    end

    // Partner status levels follow the negotiation machine directly.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pdf_r      <= 1'h0;
            lp_np_r    <= 1'h0;
            lp_an_r    <= 1'h0;
            pdf_prev_r <= 1'h0;
        end else begin
            pdf_r      <= pd_fault;
            lp_np_r    <= partner_np_capable;
            lp_an_r    <= partner_an_capable;
            pdf_prev_r <= pd_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask.

    // Sticky events; a read clears only the bits not set in the same cycle.
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (irq_read) begin
            irq_stat_nxt = `IRQ_RST;
        end
        if (page_rx_stb) begin
            irq_stat_nxt[`IRQ_PAGE_BIT] = 1'h1;
        end
        if (fault_rise) begin
            irq_stat_nxt[`IRQ_FAULT_BIT] = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_stat_r <= `IRQ_RST;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // The mask is the only register software writes.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_mask_r <= `IRQ_RST;
        end else if (mgmt_req.wr && hit(mgmt_req.addr, `ADDR_IRQ_MASK)) begin
            irq_mask_r <= mgmt_req.wdata[`IRQ_FAULT_BIT:`IRQ_PAGE_BIT];
        end
    end

    // The level follows status one cycle later, so it drops the cycle
    // after the clearing read answers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_r <= 1'h0;
        end else begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path.

    // Writes to the status words fall through unmatched and change nothing.
    always_comb begin
        rd_data_nxt = `DATA_ZERO;
        if (mgmt_req.rd) begin
            case (mgmt_req.addr)
                `ADDR_NP_ABIL:  rd_data_nxt = np_word_r;
                `ADDR_EXP_STAT: rd_data_nxt = exp_word(pdf_r, lp_np_r, page_rx_r,
                                                       lp_an_r);
                `ADDR_IRQ_STAT: rd_data_nxt = {`IRQ_PAD, irq_stat_r};
                `ADDR_IRQ_MASK: rd_data_nxt = {`IRQ_PAD, irq_mask_r};
                default:        rd_data_nxt = `DATA_ZERO;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_r <= `DATA_ZERO;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign irq     = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_page_in;
        page_rx_stb;
    endsequence

    sequence s_exp_rd;
        exp_read;
    endsequence

    sequence s_np_rd;
        mgmt_req.rd && hit(mgmt_req.addr, `ADDR_NP_ABIL);
    endsequence

    // A page, one quiet cycle, then a read of the page word; the read data
    // then carry the page taken three edges back.
    sequence s_page_then_np_rd;
        s_page_in ##1 !page_rx_stb ##1 s_np_rd;
    endsequence

    chk_confirm_capture: assert property (
        s_page_in |=> np_word_r.partner_receipt_confirm
                      == $past(page_rx_word.partner_receipt_confirm))
        else $error("receipt confirm bit not captured from page");

    chk_msg_flag_read: assert property (
        s_page_then_np_rd
            |=> rd_data[`NP_MP_BIT] == $past(page_rx_word.message_page_flag, 3))
        else $error("message page flag read back wrong");

    chk_code_stable: assert property (
        !page_rx_stb |=> np_word_r.code == $past(np_word_r.code))
        else $error("code field changed without a page");

    chk_comply_read: assert property (
        s_page_then_np_rd
            |=> rd_data[`NP_COMPLY_BIT] == $past(page_rx_word.partner_comply_flag, 3))
        else $error("comply flag read back wrong");

    chk_toggle_invert: assert property (
        s_page_in |=> np_word_r.toggle != $past(tx_toggle_last))
        else $error("toggle not inverse of transmitted toggle");

    chk_exp_answer: assert property (
        s_exp_rd |=> rd_data[`EXP_PAGE_BIT] == $past(page_rx_r)
                     && rd_data[`EXP_PDF_BIT] == $past(pdf_r))
        else $error("expansion register answer wrong");

    chk_exp_reserved: assert property (
        s_exp_rd |=> rd_data[`EXP_RSVD_HI:`EXP_RSVD_LO] == `RSVD_ZERO)
        else $error("reserved expansion bits not zero");

    chk_fault_follow: assert property (
        pd_fault ##1 s_exp_rd |=> rd_data[`EXP_PDF_BIT])
        else $error("parallel detect fault not shown");

    chk_lp_np_follow: assert property (
        partner_np_capable ##1 s_exp_rd |=> rd_data[`EXP_LP_NP_BIT])
        else $error("partner next-page capability not shown");

    chk_local_np_one: assert property (
        s_exp_rd |=> rd_data[`EXP_LOC_NP_BIT])
        else $error("local next-page bit not one");

    chk_page_clear: assert property (
        s_exp_rd and !page_rx_stb |=> !page_rx_r)
        else $error("page flag not cleared by read");

    chk_page_set: assert property (
        s_page_in |=> page_rx_r)
        else $error("page flag not set on received word");

    chk_lp_an_follow: assert property (
        !partner_an_capable ##1 s_exp_rd |=> !rd_data[`EXP_LP_AN_BIT])
        else $error("partner auto-negotiation bit wrong");

    chk_np_answer: assert property (
        s_np_rd |=> rd_data == $past(np_word_r))
        else $error("next-page word answer wrong");

    chk_np_request: assert property (
        s_page_then_np_rd
            |=> rd_data[`NP_REQ_BIT] == $past(page_rx_word.next_page_request, 3))
        else $error("next page request read back wrong");

    chk_set_beats_read: assert property (
        (s_page_in and s_exp_rd) |=> page_rx_r)
        else $error("page event lost under clearing read");

    chk_writes_ignored: assert property (
        mgmt_req.wr && !page_rx_stb |=> np_word_r == $past(np_word_r))
        else $error("management write altered the page word");

endmodule

// ===== testbench/autoneg_feeder.sv
// Behavioural model of the negotiation machine that feeds the status bank.
// Assumes the bench calls its tasks from one process at a time, on clk.
module autoneg_feeder
    import anstat_pkg::*;
(
    input  wire logic clk,
    output logic      page_rx_stb,
    output np_word_t  page_rx_word,
    output logic      tx_toggle_last,
    output logic      pd_fault,
    output logic      partner_np_capable,
    output logic      partner_an_capable
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle state: no page and no partner abilities.
    initial begin
        page_rx_stb        = 1'h0;
        page_rx_word       = 16'h0000;
        tx_toggle_last     = 1'h0;
        pd_fault           = 1'h0;
        partner_np_capable = 1'h0;
        partner_an_capable = 1'h0;
    end

    // One received code word; the word carries the partner's own receipt confirm bit.
    // After the strobe the word is inverted, so a bank that samples late is caught.
    task automatic send_page(input np_word_t w, input logic tog);
        @(posedge clk);
        page_rx_stb    <= 1'h1;
        page_rx_word   <= w;
        tx_toggle_last <= tog;
        @(posedge clk);
        page_rx_stb    <= 1'h0;
        page_rx_word   <= ~w;
        tx_toggle_last <= ~tog;
    endtask

    // Levels of the parallel detect fault and partner abilities.
    task automatic set_levels(input logic f, input logic np, input logic an);
        @(posedge clk);
        pd_fault           <= f;
        partner_np_capable <= np;
        partner_an_capable <= an;
    endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the auto-negotiation status bank.
// Assumes the bank answers reads one cycle after the read strobe.
`include "anstat_cfg.svh"

module tb
    import anstat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        sys_rst;
    mgmt_req_t   mgmt_req;
    logic [15:0] rd_data;
    logic        irq;
    logic        page_rx_stb;
    np_word_t    page_rx_word;
    logic        tx_toggle_last;
    logic        pd_fault;
    logic        partner_np_capable;
    logic        partner_an_capable;
    int          n_fail;
    int          samples_checked;
    logic [15:0] d;
    logic [15:0] last_np;
    logic [15:0] words [4] = '{16'h2123, 16'h07FF, 16'h5000, 16'hB800};

    autoneg_status i_dut (
        .clk(clk), .sys_rst(sys_rst), .mgmt_req(mgmt_req), .rd_data(rd_data), .irq(irq),
        .page_rx_stb(page_rx_stb), .page_rx_word(page_rx_word),
        .tx_toggle_last(tx_toggle_last), .pd_fault(pd_fault),
        .partner_np_capable(partner_np_capable), .partner_an_capable(partner_an_capable)
    );

    autoneg_feeder u_far (
        .clk(clk), .page_rx_stb(page_rx_stb), .page_rx_word(page_rx_word),
        .tx_toggle_last(tx_toggle_last), .pd_fault(pd_fault),
        .partner_np_capable(partner_np_capable), .partner_an_capable(partner_an_capable)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock.
    always #5 clk = ~clk;

    // Single-cycle write strobe.
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        mgmt_req <= '{addr: a, wdata: v, wr: 1'h1, rd: 1'h0};
        @(posedge clk);
        mgmt_req.wr <= 1'h0;
    endtask

    // Single-cycle read; the data stand only in the cycle after the strobe.
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk);
        mgmt_req <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
        @(posedge clk);
        mgmt_req.rd <= 1'h0;
        #1 v = rd_data;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic finish_test;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Whole run needs well under 1000 cycles; a hang is cut short.
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        clk = 1'h0;
        sys_rst = 1'h1;
        mgmt_req = '0;
        n_fail = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        rd(`ADDR_NP_ABIL, d);
        chk("np_word_rst", 16'h0000, d);
        rd(`ADDR_EXP_STAT, d);
        chk("exp_rst", 16'h0004, d);
        wr(`ADDR_IRQ_MASK, 16'h0003);
        u_far.set_levels(1'h1, 1'h1, 1'h1);
        repeat (3) @(posedge clk);
        #1 chk("irq_fault", 16'h0001, {15'h0000, irq});
        rd(`ADDR_EXP_STAT, d);
        chk("exp_levels", 16'h001D, d);
        rd(`ADDR_IRQ_STAT, d);
        chk("irq_stat_fault", 16'h0002, d);
        repeat (2) @(posedge clk);
        #1 chk("irq_clear", 16'h0000, {15'h0000, irq});
        // Message, unformatted, comply and next-page words with both toggle values.
        for (int i = 0; i < 4; i++) begin
            u_far.send_page(words[i], i[0]);
            last_np = (words[i] & 16'hF7FF) | {4'h0, ~i[0], 11'h000};
            // Read straight after the page, so the read-back checks see it.
            rd(`ADDR_NP_ABIL, d);
            chk("np_word", last_np, d);
            chk("irq_page", 16'h0001, {15'h0000, irq});
            rd(`ADDR_EXP_STAT, d);
            chk("exp_page_set", 16'h001F, d);
            rd(`ADDR_EXP_STAT, d);
            chk("exp_page_cor", 16'h001D, d);
            rd(`ADDR_IRQ_STAT, d);
            chk("irq_stat_page", 16'h0001, d);
        end
        // Writes to read-only words must not stick; software leaves the
        // receipt confirm bit alone, as the negotiation machine owns it.
        wr(`ADDR_NP_ABIL, 16'hBFFF);
        wr(`ADDR_EXP_STAT, 16'hFFFF);
        wr(`ADDR_IRQ_STAT, 16'hFFFF);
        rd(`ADDR_NP_ABIL, d);
        chk("np_word_wr", last_np, d);
        rd(`ADDR_EXP_STAT, d);
        chk("exp_wr", 16'h001D, d);
        rd(5'h1F, d);
        chk("unmapped", 16'h0000, d);
        // A page that lands with the clearing read must survive it.
        fork
            u_far.send_page(16'h2555, 1'h1);
            rd(`ADDR_EXP_STAT, d);
        join
        chk("exp_race_rd", 16'h001D, d);
        rd(`ADDR_EXP_STAT, d);
        chk("exp_race", 16'h001F, d);
        rd(`ADDR_IRQ_STAT, d);
        chk("irq_stat_race", 16'h0001, d);
        // Page interrupt masked off.
        wr(`ADDR_IRQ_MASK, 16'h0002);
        u_far.send_page(16'h0001, 1'h0);
        repeat (3) @(posedge clk);
        #1 chk("irq_masked", 16'h0000, {15'h0000, irq});
        rd(`ADDR_IRQ_STAT, d);
        chk("irq_stat_masked", 16'h0001, d);
        rd(`ADDR_IRQ_MASK, d);
        chk("irq_mask", 16'h0002, d);
        // Second reset in mid-run returns every word to its default.
        u_far.set_levels(1'h0, 1'h0, 1'h0);
        @(posedge clk);
        sys_rst <= 1'h1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        rd(`ADDR_NP_ABIL, d);
        chk("np_word_rst2", 16'h0000, d);
        rd(`ADDR_EXP_STAT, d);
        chk("exp_rst2", 16'h0004, d);
        rd(`ADDR_IRQ_MASK, d);
        chk("irq_mask_rst2", 16'h0000, d);
        finish_test();
    end
endmodule
